// File: rtl/ibcs_pkg.sv
// package: shared constants and types for the inter-bank command scheduler
package ibcs_pkg;
   localparam int             NUM_BANKS       = 8;
   localparam int             BANK_W          = 3;
   localparam int             ADDR_W          = 15;
   localparam int             AP_BIT          = 10;
   localparam int             CNT_W           = 8;
   localparam int             CLK_PERIOD_PS   = 20000;
   // timings in ps, counts derived by rounding up
   localparam int             WTR_PS          = 7500;
   localparam int             RP_PS           = 12500;
   localparam int             RCD_PS          = 12500;
   localparam int             WR_PS           = 15000;
   localparam int             XSNR_PS         = 137500;
   localparam int             WTR_RAW         = (WTR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int             WTR_CYC         = (WTR_RAW > 2) ? WTR_RAW : 2;
   localparam int             RP_CYC          = (RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int             RCD_CYC         = (RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int             WR_CYC          = (WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int             XSNR_CYC        = (XSNR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int             READ_LAT        = 5;
   localparam int             BURST_LEN       = 8;
   localparam int             ONE_CLK         = 1;
   localparam int             RD_TO_WR_EXTRA  = 2;
   // command codes {ras_n, cas_n, we_n}
   typedef enum logic [2:0] {
      IBCS_CMD_ACT  = 3'h3,
      IBCS_CMD_RD   = 3'h5,
      IBCS_CMD_WR   = 3'h4,
      IBCS_CMD_PRE  = 3'h2,
      IBCS_CMD_REF  = 3'h1,
      IBCS_CMD_LMR  = 3'h0,
      IBCS_CMD_NOP  = 3'h7
   } ibcs_cmd_type;
   // per-bank state, gray in the listed order idle, activating, active, read, write, read-ap, write-ap, precharge
   typedef enum logic [2:0] {
      IBCS_IDLE    = 3'h0,
      IBCS_ACTING  = 3'h1,
      IBCS_ACTIVE  = 3'h3,
      IBCS_READ    = 3'h2,
      IBCS_WRITE   = 3'h6,
      IBCS_RD_AP   = 3'h7,
      IBCS_WR_AP   = 3'h5,
      IBCS_PRECH   = 3'h4
   } ibcs_bank_type;
endpackage

// File: rtl/ibcs_if.sv
// interface: command pins between controller and memory device
`timescale 1ns/1ps
interface ibcs_if;
   logic                         cke;
   logic                         cs_n;
   logic                         ras_n;
   logic                         cas_n;
   logic                         we_n;
   logic [ibcs_pkg::BANK_W-1:0]  ba;
   logic [ibcs_pkg::ADDR_W-1:0]  addr;
   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr);
   modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

// File: rtl/ibcs_device.sv
// device end: decodes commands and tracks per-bank state
`timescale 1ns/1ps
// how this end behaves:
// - watches the command pins the way the memory does, one decode per rising edge
// - decodes only while clock enable has been high on this edge and the one before
// - a self-refresh exit pulse blocks decoding until the exit delay drains
// - deselect and nop start nothing; whatever a bank is doing runs on
// - the bank pins name the bank a command acts on, or the register a mode load writes
// - every bank has its own state and down counter, so banks never wait on each other
// - a burst or an auto-precharge in one bank leaves commands to the others untouched
// - read with auto-precharge enters precharge once its burst data is out
// - write with auto-precharge enters precharge once write recovery is over
// - a precharge behind a read still bursting waits for the data before going idle
// - each decoded command shows for one clock on cmd_valid with its code and bank
// - mode load also pulses mode_load with the selected register
// limitation: the device trusts the controller; an illegal sequence is decoded as sent,
// and keeping read and write data apart on the shared bus is left to the controller
// trade-off: one counter per bank costs a few flops but keeps every bank independent
// Contract
// - decode only with cke high two edges
// - rules pair one bank with others
// - deselect or nop starts nothing new
// - idle bank imposes no restriction
// - decode act read write precharge
// - active or bursting bank allows others
// - idle after precharge, trp, read done
// - active after activate plus activate_to_column_delay
// - read/write state until burst ends
// - auto-precharge splits access, precharge
// - read ap precharges at earliest point
// - write ap precharges after write recovery
// - accept other banks during auto-precharge
// - controller avoids data bus collisions
// - refresh and mode load all idle
// - controller issues only permitted combinations
// - read/write entries cover both variants
// - write after read burst completes
// - turnaround is max of two, ratio
// - delays after write with auto-precharge
// - delays after read with auto-precharge
// - sample pins on rising edge
// - bank address selects bank or register
module ibcs_device #(
   parameter int XSNR_CYCLES = ibcs_pkg::XSNR_CYC
) (
   input  wire logic                                  clk_sys,
   input  wire logic                                  rst_n,
   ibcs_if.dev                                        mem,
   input  wire logic                                  self_refresh_exit,
   output logic [ibcs_pkg::NUM_BANKS-1:0][2:0]        bank_state,
   output logic                                       all_idle,
   output logic                                       cmd_valid,
   output logic [2:0]                                 cmd_code,
   output logic [ibcs_pkg::BANK_W-1:0]                cmd_bank,
   output logic                                       mode_load,
   output logic [ibcs_pkg::BANK_W-1:0]                mode_sel
);
   import ibcs_pkg::*;

   // ------------------------------------------------------------------
   // state record and per-bank counts
   // ------------------------------------------------------------------
   // a bank's counter is the time left in its current state; the state moves on
   // only when the counter is zero, and a new command to that bank reloads both
   // at once, so no bank ever reads or writes another bank's fields
   typedef struct packed {
      logic                              cke_prev;
      logic [15:0]                       xsnr_cnt;
      ibcs_bank_type [NUM_BANKS-1:0]     st;
      logic [NUM_BANKS-1:0][CNT_W-1:0]   cnt;
      logic                              all_idle;
      logic                              cmd_valid;
      logic [2:0]                        cmd_code;
      logic [BANK_W-1:0]                 cmd_bank;
      logic                              mode_load;
      logic [BANK_W-1:0]                 mode_sel;
   } ibcs_dev_type;

   // clocks spent in each state, counted from the edge that takes the command
   localparam logic [CNT_W-1:0] RD_BURST = CNT_W'(BURST_LEN / 2);
   localparam logic [CNT_W-1:0] WR_BURST = CNT_W'(READ_LAT - 1 + BURST_LEN / 2);
   localparam logic [CNT_W-1:0] WR_REC   = CNT_W'(READ_LAT - 1 + BURST_LEN / 2 + WR_CYC);
   localparam logic [CNT_W-1:0] RP_CNT   = CNT_W'(RP_CYC);
   localparam logic [CNT_W-1:0] RCD_CNT  = CNT_W'(RCD_CYC);

   ibcs_dev_type     r;
   ibcs_dev_type     next_r;
   logic             enabled;
   logic [2:0]       code;
   logic             ap;
   logic [CNT_W-1:0] pre_hold;

   // ------------------------------------------------------------------
   // command decode and bank state update
   // ------------------------------------------------------------------
   always_comb begin
      next_r          = r;
      next_r.cke_prev = mem.cke;
      // exit delay: nothing is decoded until this counter drains
      if (r.xsnr_cnt != 16'h0000) begin
         next_r.xsnr_cnt = r.xsnr_cnt - 16'h0001;
      end
      if (self_refresh_exit) begin
         next_r.xsnr_cnt = 16'(XSNR_CYCLES);
      end
      // an exit pulse on the same edge as a command wins and the command is dropped
      enabled = r.cke_prev && mem.cke && (r.xsnr_cnt == 16'h0000) && !self_refresh_exit;
      code    = {mem.ras_n, mem.cas_n, mem.we_n};
      ap      = mem.addr[AP_BIT];
      // a precharge must not cut a read burst still leaving the bank; it waits
      // out whatever is longer, the burst tail or the row-precharge time
      pre_hold = RP_CNT;
      if ((r.st[mem.ba] == IBCS_READ || r.st[mem.ba] == IBCS_RD_AP) && r.cnt[mem.ba] > RP_CNT) begin
         pre_hold = r.cnt[mem.ba];
      end
      // every bank advances on its own; commands to bank m never disturb bank n
      // a bank leaves a timed state on the clock after its counter has drained
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (r.cnt[b] != '0) begin
            next_r.cnt[b] = r.cnt[b] - 1'b1;
         end else begin
            case (r.st[b])
               IBCS_ACTING: next_r.st[b] = IBCS_ACTIVE;
               IBCS_READ:   next_r.st[b] = IBCS_ACTIVE;
               IBCS_WRITE:  next_r.st[b] = IBCS_ACTIVE;
               IBCS_RD_AP, IBCS_WR_AP: begin
                  // access period over, the precharge period starts here
                  next_r.st[b]  = IBCS_PRECH;
                  next_r.cnt[b] = RP_CNT;
               end
               IBCS_PRECH:  next_r.st[b] = IBCS_IDLE;
               default:     next_r.st[b] = r.st[b];
            endcase
         end
      end
      // report pulses drop back every clock unless a command is taken
      next_r.cmd_valid = 1'b0;
      next_r.mode_load = 1'b0;
      // deselect and nop leave every bank running
      if (enabled && !mem.cs_n && code != IBCS_CMD_NOP) begin
         next_r.cmd_valid = 1'b1;
         next_r.cmd_code  = code;
         next_r.cmd_bank  = mem.ba;
         case (code)
            IBCS_CMD_ACT: begin
               next_r.st[mem.ba]  = IBCS_ACTING;
               next_r.cnt[mem.ba] = RCD_CNT;
            end
            IBCS_CMD_RD: begin
               // the ap bit picks the variant; both share the burst count
               next_r.st[mem.ba]  = ap ? IBCS_RD_AP : IBCS_READ;
               next_r.cnt[mem.ba] = RD_BURST;
            end
            IBCS_CMD_WR: begin
               next_r.st[mem.ba]  = ap ? IBCS_WR_AP : IBCS_WRITE;
               // with ap the bank also waits out write recovery before precharging
               next_r.cnt[mem.ba] = ap ? WR_REC : WR_BURST;
            end
            IBCS_CMD_PRE: begin
               next_r.st[mem.ba]  = IBCS_PRECH;
               next_r.cnt[mem.ba] = pre_hold;
            end
            IBCS_CMD_LMR: begin
               // a mode load touches no bank; the bank pins pick the register
               next_r.mode_load = 1'b1;
               next_r.mode_sel  = mem.ba;
            end
            default: ;
         endcase
      end
      // built from the next state so it lines up with bank_state
      next_r.all_idle = 1'b1;
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (next_r.st[b] != IBCS_IDLE) begin
            next_r.all_idle = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      // reset leaves every bank idle; all_idle is the one field that resets high
      if (!rst_n) begin
         r          <= '0;
         r.all_idle <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------------
   // outputs, all straight from the state register
   // ------------------------------------------------------------------
   // one lane per bank; the enum is flattened to its three code bits
   for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank_out
      assign bank_state[g] = r.st[g];
   end
   // command report stands for one clock after the edge that took the command
   assign all_idle  = r.all_idle;
   assign cmd_valid = r.cmd_valid;
   assign cmd_code  = r.cmd_code;
   assign cmd_bank  = r.cmd_bank;
   assign mode_load = r.mode_load;
   assign mode_sel  = r.mode_sel;
endmodule

// File: rtl/ibcs_ctrl.sv
// controller end: per-bank tracking and inter-bank delay gating
`timescale 1ns/1ps
module ibcs_ctrl (
   input  wire logic                          clk_sys,
   input  wire logic                          rst_n,
   ibcs_if.ctrl                               mem,
   input  wire logic                          req_valid,
   input  wire logic [2:0]                    req_cmd,
   input  wire logic [ibcs_pkg::BANK_W-1:0]   req_bank,
   input  wire logic [ibcs_pkg::ADDR_W-1:0]   req_addr,
   output logic                               req_ready,
   output logic                               req_taken
);
   import ibcs_pkg::*;

   typedef struct packed {
      logic [NUM_BANKS-1:0][CNT_W-1:0] busy;
      logic [NUM_BANKS-1:0]            open;
      logic [CNT_W-1:0]                rd_gap;
      logic [CNT_W-1:0]                wr_gap;
      logic [CNT_W-1:0]                rc_gap;
      logic                            ready;
      logic                            taken;
      logic                            cke;
      logic [2:0]                      code;
      logic [BANK_W-1:0]               ba;
      logic [ADDR_W-1:0]               addr;
   } ibcs_ctl_type;

   localparam logic [CNT_W-1:0] HALF_BL  = CNT_W'(BURST_LEN / 2);
   localparam logic [CNT_W-1:0] WAP_RD   = CNT_W'(READ_LAT - 1 + BURST_LEN / 2 + WTR_CYC);
   localparam logic [CNT_W-1:0] RAP_WR   = CNT_W'(BURST_LEN / 2 + RD_TO_WR_EXTRA);
   localparam logic [CNT_W-1:0] ONE      = CNT_W'(ONE_CLK);
   localparam logic [CNT_W-1:0] BANK_BSY = CNT_W'(READ_LAT + BURST_LEN / 2 + WR_CYC + RP_CYC + RCD_CYC);

   ibcs_ctl_type r;
   ibcs_ctl_type next_r;
   logic         ok;
   logic         all_idle;
   logic         closes;

   function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
      dec = (v != '0) ? v - 1'b1 : v;
   endfunction

   function automatic logic [CNT_W-1:0] maxc(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
      maxc = (a > b) ? a : b;
   endfunction

   // ------------------------------------------------------------------
   // gate requests on inter-bank delays and issue at most one command every two clocks
   // ------------------------------------------------------------------
   always_comb begin
      next_r        = r;
      next_r.cke    = 1'b1;
      next_r.taken  = 1'b0;
      next_r.code   = IBCS_CMD_NOP;
      next_r.rd_gap = dec(r.rd_gap);
      next_r.wr_gap = dec(r.wr_gap);
      next_r.rc_gap = dec(r.rc_gap);
      all_idle      = 1'b1;
      // an open row keeps refresh and mode load out however long ago it was opened
      if (r.open != '0) begin
         all_idle = 1'b0;
      end
      // an access with the ap bit closes its row by itself
      closes        = req_addr[AP_BIT] && (req_cmd == IBCS_CMD_RD || req_cmd == IBCS_CMD_WR);
      for (int b = 0; b < NUM_BANKS; b++) begin
         next_r.busy[b] = dec(r.busy[b]);
         if (r.busy[b] != '0) begin
            all_idle = 1'b0;
         end
      end
      // conservative: the whole-bank busy window also covers same-bank
      case (req_cmd)
         IBCS_CMD_RD:  ok = (r.rd_gap == '0);
         IBCS_CMD_WR:  ok = (r.wr_gap == '0);
         IBCS_CMD_ACT: ok = (r.rc_gap == '0) && (r.busy[req_bank] == '0);
         IBCS_CMD_PRE: ok = (r.rc_gap == '0);
         IBCS_CMD_REF, IBCS_CMD_LMR: ok = all_idle && (r.rc_gap == '0);
         default:      ok = 1'b0;
      endcase
      if (req_valid && r.ready && ok) begin
         next_r.taken = 1'b1;
         next_r.code  = req_cmd;
         next_r.ba    = req_bank;
         next_r.addr  = req_addr;
         next_r.rc_gap = maxc(next_r.rc_gap, ONE);
         case (req_cmd)
            IBCS_CMD_RD: begin
               next_r.rd_gap = maxc(next_r.rd_gap, HALF_BL);
               next_r.wr_gap = maxc(next_r.wr_gap, RAP_WR);
            end
            IBCS_CMD_WR: begin
               next_r.rd_gap = maxc(next_r.rd_gap, WAP_RD);
               next_r.wr_gap = maxc(next_r.wr_gap, HALF_BL);
            end
            IBCS_CMD_ACT: next_r.busy[req_bank] = BANK_BSY;
            default: ;
         endcase
         // track open rows; a closing bank stays busy until its precharge is surely over
         if (req_cmd == IBCS_CMD_ACT) begin
            next_r.open[req_bank] = 1'b1;
         end else if (req_cmd == IBCS_CMD_PRE || closes) begin
            next_r.open[req_bank] = 1'b0;
            next_r.busy[req_bank] = maxc(next_r.busy[req_bank], BANK_BSY);
         end
      end
      next_r.ready = !(req_valid && r.ready && ok);                 // one command, then a nop slot
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r      <= '0;
         r.code <= IBCS_CMD_NOP;
      end else begin
         r <= next_r;
      end
   end

   assign mem.cke   = r.cke;
   assign mem.cs_n  = (r.code == IBCS_CMD_NOP);
   assign mem.ras_n = r.code[2];
   assign mem.cas_n = r.code[1];
   assign mem.we_n  = r.code[0];
   assign mem.ba    = r.ba;
   assign mem.addr  = r.addr;
   assign req_ready = r.ready;
   assign req_taken = r.taken;
endmodule

// File: testbench/ibcs_asserts.sv
// checker: timing relations on the command pins between controller and device
`timescale 1ns/1ps
module ibcs_asserts
   import ibcs_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic               cke,
   input  wire logic               cs_n,
   input  wire logic               ras_n,
   input  wire logic               cas_n,
   input  wire logic               we_n,
   input  wire logic [BANK_W-1:0]  ba,
   input  wire logic [ADDR_W-1:0]  addr
);
   // ---------------------------------------------------------------
   // decoded pin views
   // ---------------------------------------------------------------
   logic  is_cmd;
   logic  is_rd;
   logic  is_wr;
   // column strobes only, so both precharge variants count alike
   assign is_cmd = !cs_n;
   assign is_rd  = !cs_n && ras_n && !cas_n && we_n;
   assign is_wr  = !cs_n && ras_n && !cas_n && !we_n;

   // clocks since the last write on the pins, saturating so a long quiet spell never wraps
   localparam int        WR_RD_MIN = READ_LAT - 1 + BURST_LEN / 2 + WTR_CYC;
   logic [CNT_W-1:0]     wr_age;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_age <= '1;
      end else if (is_wr) begin
         wr_age <= CNT_W'(1);
      end else if (wr_age != '1) begin
         wr_age <= wr_age + 1'b1;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // ---------------------------------------------------------------
   // spacing and framing of commands
   // ---------------------------------------------------------------
   a_nop_after_cmd: assert property (is_cmd |=> cs_n)
      else $error("command not followed by a deselect slot");
   a_cke_before_cmd: assert property (is_cmd |-> cke && $past(cke))
      else $error("command without clock enable on two edges");
   a_cke_stays_high: assert property ($past(cke) |-> cke)
      else $error("clock enable dropped after reset");
   a_no_nop_code: assert property (is_cmd |-> !(ras_n && cas_n && we_n))
      else $error("selected no-op driven as a command");
   a_wr_rd_gap: assert property (is_rd |-> wr_age >= CNT_W'(WR_RD_MIN))
      else $error("read too soon after write");
   a_rd_wr_gap: assert property (is_rd |=> !is_wr [*5])
      else $error("write too soon after read");
   a_rd_rd_gap: assert property (is_rd |=> !is_rd [*3])
      else $error("read too soon after read");
   a_wr_wr_gap: assert property (is_wr |=> !is_wr [*3])
      else $error("write too soon after write");

   // main scenarios reached
   c_wrap_then_rd: cover property (is_wr && addr[AP_BIT] ##[1:40] is_rd);
   c_rdap_then_wr: cover property (is_rd && addr[AP_BIT] ##[1:40] is_wr);
   c_refresh: cover property (!cs_n && !ras_n && !cas_n && we_n);
endmodule

// File: testbench/tb_interbank_command_scheduler.sv
// testbench: controller and device joined, requests driven, device decode checked against a model
`timescale 1ns/1ps
module tb_interbank_command_scheduler;
   import ibcs_pkg::*;
   localparam int XSNR = 4;
   logic                      clk_sys, rst_n, req_valid, req_ready, req_taken;
   logic                      self_refresh_exit, all_idle, cmd_valid, mode_load;
   logic [2:0]                req_cmd, cmd_code;
   logic [BANK_W-1:0]         req_bank, cmd_bank, mode_sel;
   logic [ADDR_W-1:0]         req_addr;
   logic [NUM_BANKS-1:0][2:0] bank_state;
   logic [7:0]                exp_q[$];
   int                        n_fail, tests_run;

   ibcs_if mem_if();
   ibcs_ctrl ibcs_ctrl_i(.clk_sys(clk_sys), .rst_n(rst_n), .mem(mem_if), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_ready(req_ready),
      .req_taken(req_taken));
   ibcs_device #(.XSNR_CYCLES(XSNR)) ibcs_device_i(.clk_sys(clk_sys), .rst_n(rst_n), .mem(mem_if),
      .self_refresh_exit(self_refresh_exit), .bank_state(bank_state), .all_idle(all_idle),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank), .mode_load(mode_load),
      .mode_sel(mode_sel));
   ibcs_asserts ibcs_asserts_i(.clk_sys(clk_sys), .rst_n(rst_n), .cke(mem_if.cke), .cs_n(mem_if.cs_n),
      .ras_n(mem_if.ras_n), .cas_n(mem_if.cas_n), .we_n(mem_if.we_n), .ba(mem_if.ba),
      .addr(mem_if.addr));

   // ---------------------------------------------------------------
   // checking helpers
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // bank state the device should report on the cycle it flags a command
   function automatic logic [2:0] exp_state(input logic [7:0] e);
      case (e[6:4])
         IBCS_CMD_ACT: return IBCS_ACTING;
         IBCS_CMD_RD:  return e[3] ? IBCS_RD_AP : IBCS_READ;
         IBCS_CMD_WR:  return e[3] ? IBCS_WR_AP : IBCS_WRITE;
         IBCS_CMD_PRE: return IBCS_PRECH;
         default:      return IBCS_IDLE;
      endcase
   endfunction

   // mode 0 refused, 1 taken and decoded, 2 taken but ignored by the device
   task automatic issue(input logic [2:0] c, input int b, input logic ap, input int mode);
      int k;
      req_cmd = c;
      req_bank = 3'(b);
      req_addr = 15'($urandom);
      req_addr[AP_BIT] = ap;
      req_valid = 1'b1;
      k = 0;
      while (req_taken !== 1'b1 && k < ((mode == 0) ? 30 : 300)) begin
         @(negedge clk_sys);
         k++;
      end
      req_valid = 1'b0;
      check("req_taken", 8'(mode != 0), 8'(req_taken));
      check("req_ready", 8'(mode == 0), 8'(req_ready));
      if (mode == 1) exp_q.push_back({1'b0, c, ap, 3'(b)});
      @(negedge clk_sys);
   endtask

   // ---------------------------------------------------------------
   // model compare: every decoded command must match the next one sent
   // ---------------------------------------------------------------
   always @(negedge clk_sys) begin
      logic [7:0] e;
      if (rst_n === 1'b1 && cmd_valid === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hff;
         check("cmd_code", 8'(e[6:4]), 8'(cmd_code));
         check("cmd_bank", 8'(e[2:0]), 8'(cmd_bank));
         check("bank_state", 8'(exp_state(e)), 8'(bank_state[cmd_bank]));
         if (e[6:4] == IBCS_CMD_LMR) begin
            check("mode_sel", 8'(e[2:0]), 8'(mode_sel));
            check("mode_load", 8'h01, 8'(mode_load));
         end
      end
   end

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // a hang is cut after far more cycles than the sequence needs
   initial begin
      #400000;
      n_fail++;
      results();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic ap [NUM_BANKS];
      int   k;
      void'($urandom(88506));
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_cmd = IBCS_CMD_NOP;
      req_bank = '0;
      req_addr = '0;
      self_refresh_exit = 1'b0;
      n_fail = 0;
      tests_run = 0;
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      check("all_idle", 8'h01, 8'(all_idle));
      issue(IBCS_CMD_NOP, 1, 1'b0, 0);
      // open every bank, then interleave bursts across banks back to back
      for (int b = 0; b < NUM_BANKS; b++) issue(IBCS_CMD_ACT, b, 1'b0, 1);
      for (int b = 0; b < NUM_BANKS; b++) begin
         ap[b] = (b < 4) ? b[1] : 1'($urandom);
         issue(((b < 4) ? b[0] : 1'($urandom)) ? IBCS_CMD_WR : IBCS_CMD_RD, b, ap[b], 1);
      end
      for (int b = 0; b < NUM_BANKS; b++) if (!ap[b]) issue(IBCS_CMD_PRE, b, 1'b0, 1);
      k = 0;
      while (all_idle !== 1'b1 && k < 200) begin
         @(negedge clk_sys);
         k++;
      end
      check("all_idle", 8'h01, 8'(all_idle));
      issue(IBCS_CMD_REF, 0, 1'b0, 1);
      issue(IBCS_CMD_LMR, 2, 1'b0, 1);
      // refresh with one bank open must be held back
      issue(IBCS_CMD_ACT, 3, 1'b0, 1);
      issue(IBCS_CMD_REF, 0, 1'b0, 0);
      issue(IBCS_CMD_PRE, 3, 1'b0, 1);
      // a command inside the exit delay is dropped by the device
      self_refresh_exit = 1'b1;
      @(negedge clk_sys);
      self_refresh_exit = 1'b0;
      issue(IBCS_CMD_ACT, 5, 1'b0, 2);
      repeat (XSNR + 2) @(negedge clk_sys);
      issue(IBCS_CMD_ACT, 5, 1'b0, 1);
      issue(IBCS_CMD_PRE, 5, 1'b0, 1);
      repeat (20) @(negedge clk_sys);
      check("pending", 8'h00, 8'(exp_q.size()));
      results();
   end
endmodule
